// ===== rtl/sequencer_defines.svh
`ifndef SEQUENCER_DEFINES_SVH
`define SEQUENCER_DEFINES_SVH
`define CLK_MHZ 10
`define LAT_US 270
`define LAT_CYC (`LAT_US * `CLK_MHZ)
`define JIT_US 50
`define DLY_CYC ((`LAT_US - `JIT_US) * `CLK_MHZ)
`define TICK_US 100
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define DGL_US 70
`define DGL_CYC (`DGL_US * `CLK_MHZ)
`define SKIP_US 250
`define SERVO_MS 90
`define SERVO_CYC (`SERVO_MS * 1000 * `CLK_MHZ)
`define DROOP_MAX 16'h0096
`define UV_PROP_BIT 12
`define SERVO_EN_BIT 6
`define A_CTRL 8'h00
`define A_MODE 8'h04
`define A_VCMD 8'h08
`define A_TOND 8'h0C
`define A_TONR 8'h10
`define A_TOFD 8'h14
`define A_TOFF 8'h18
`define A_TMAX 8'h1C
`define A_DRP 8'h20
`define A_WARN 8'h24
`define A_UVT 8'h28
`define A_PROP 8'h2C
`define A_RESP 8'h30
`define A_STAT 8'h34
`define RST_DRP 16'h0000
`define RST_PROP 16'h0000
`endif

// ===== rtl/sequencer_pkg.sv
package sequencer_pkg;
	typedef enum logic [2:0] {
		ST_OFF, ST_ON_LAT, ST_ON_DLY, ST_RISE,
		ST_ON, ST_OFF_LAT, ST_OFF_DLY, ST_FALL
	} seq_state_e;
endpackage : sequencer_pkg

// ===== rtl/output_sequencing_servo_control.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sequencer_defines.svh"
module output_sequencing_servo_control
	import sequencer_pkg::*;
#(
	parameter int SERVO_CYC = `SERVO_CYC
)(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic run_in,
	input wire logic vin_ok_in,
	input wire logic init_done_in,
	input wire logic feedback_pin_strap_in,
	input wire logic [15:0] adc_vout_in,
	input wire logic [15:0] iout_in,
	input wire logic undervoltage_fault_in,
	input wire logic overcurrent_fault_in,
	output logic [15:0] dac_out,
	output logic range_out,
	output logic run_release_out,
	output logic fault_pin_out,
	output logic fault_pin_oe_out
);
	// ****************************************
	// reset and pin synchronisers
	// ****************************************
	logic rst_a_r, rst_n;
	logic [1:0] run_s_r, vin_s_r, strap_s_r;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_a_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_a_r <= 1'b1;
			rst_n <= rst_a_r;
		end
	end

	// first stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_s_r <= 2'h0;
			vin_s_r <= 2'h0;
			strap_s_r <= 2'h0;
		end
		else
		begin
			run_s_r <= {run_s_r[0], run_in};
			vin_s_r <= {vin_s_r[0], vin_ok_in};
			strap_s_r <= {strap_s_r[0], feedback_pin_strap_in};
		end
	end

	// ****************************************
	// register file over apb
	// ****************************************
	logic [15:0] ctrl_r, mode_r, vcmd_r, tond_r, tonr_r, tofd_r;
	logic [15:0] toff_r, tmax_r, drp_r, warn_r, uvt_r, prop_r, resp_r;
	logic [31:0] stat_w;
	logic wr_en, setup, sp_wr;
	logic [31:0] rd_w;
	logic hit_w;
	assign setup = psel_in && !penable_in;
	// write lands on the completing access edge only
	assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
	assign sp_wr = wr_en && paddr_in == `A_VCMD;
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= 16'h0000;
			mode_r <= 16'h0000;
			vcmd_r <= 16'h0000;
			tond_r <= 16'h0000;
			tonr_r <= 16'h0000;
			tofd_r <= 16'h0000;
			toff_r <= 16'h0000;
			tmax_r <= 16'h0000;
			drp_r <= `RST_DRP;
			warn_r <= 16'h0000;
			uvt_r <= 16'h0000;
			prop_r <= `RST_PROP;
			resp_r <= 16'h0000;
		end
		else if (wr_en)
		begin
			case (paddr_in)
				`A_CTRL: ctrl_r <= pwdata_in[15:0];
				`A_MODE: mode_r <= pwdata_in[15:0];
				`A_VCMD: vcmd_r <= pwdata_in[15:0];
				`A_TOND: tond_r <= pwdata_in[15:0];
				`A_TONR: tonr_r <= pwdata_in[15:0];
				`A_TOFD: tofd_r <= pwdata_in[15:0];
				`A_TOFF: toff_r <= pwdata_in[15:0];
				`A_TMAX: tmax_r <= pwdata_in[15:0];
				`A_DRP: drp_r <= pwdata_in[15:0];
				`A_WARN: warn_r <= pwdata_in[15:0];
				`A_UVT: uvt_r <= pwdata_in[15:0];
				`A_PROP: prop_r <= pwdata_in[15:0];
				`A_RESP: resp_r <= pwdata_in[15:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses answer zero with an error
	always_comb
	begin
		hit_w = 1'b1;
		rd_w = 32'h0000_0000;
		case (paddr_in)
			`A_CTRL: rd_w = {16'h0000, ctrl_r};
			`A_MODE: rd_w = {16'h0000, mode_r};
			`A_VCMD: rd_w = {16'h0000, vcmd_r};
			`A_TOND: rd_w = {16'h0000, tond_r};
			`A_TONR: rd_w = {16'h0000, tonr_r};
			`A_TOFD: rd_w = {16'h0000, tofd_r};
			`A_TOFF: rd_w = {16'h0000, toff_r};
			`A_TMAX: rd_w = {16'h0000, tmax_r};
			`A_DRP: rd_w = {16'h0000, drp_r};
			`A_WARN: rd_w = {16'h0000, warn_r};
			`A_UVT: rd_w = {16'h0000, uvt_r};
			`A_PROP: rd_w = {16'h0000, prop_r};
			`A_RESP: rd_w = {16'h0000, resp_r};
			`A_STAT: rd_w = stat_w;
			default: hit_w = 1'b0;
		endcase
	end

	// data is latched in setup so access completes with no wait
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
			pready_out <= 1'b0;
		end
		else
		begin
			pready_out <= 1'b1;
			if (setup)
			begin
				prdata_out <= pwrite_in ? 32'h0000_0000 : rd_w;
				pslverr_out <= !hit_w;
			end
		end
	end

	// ****************************************
	// timebase, run condition, set point latency
	// ****************************************
	localparam logic [11:0] LAT_LD = 12'(`LAT_CYC - 1);
	// on/off paths wait 220 us, then align to the next step: 220 to 320 us
	localparam logic [11:0] DLY_LD = 12'(`DLY_CYC - 1);
	localparam logic [9:0] TICK_LD = 10'(`TICK_CYC - 1);
	logic [9:0] tick_cnt_r;
	logic tick;
	logic [11:0] sp_lat_r;
	logic sp_pend_r;
	logic [15:0] sp_act_r;
	logic run_cond, flt;
	assign tick = tick_cnt_r == 10'h000;
	assign flt = undervoltage_fault_in || overcurrent_fault_in;
	assign run_cond = run_s_r[1] && ctrl_r[0] && run_release_out;
	// free 100 us step clock shared by the on/off delay, ramp and on-max counts
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt_r <= TICK_LD;
		else
			tick_cnt_r <= tick ? TICK_LD : tick_cnt_r - 10'h001;
	end

	// new set points count latency from the bus transfer's end
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp_lat_r <= 12'h000;
			sp_pend_r <= 1'b0;
			sp_act_r <= 16'h0000;
		end
		else if (sp_wr)
		begin
			sp_lat_r <= LAT_LD;
			sp_pend_r <= 1'b1;
		end
		else if (sp_pend_r)
		begin
			if (sp_lat_r == 12'h000)
			begin
				sp_act_r <= vcmd_r;
				sp_pend_r <= 1'b0;
			end
			else
				sp_lat_r <= sp_lat_r - 12'h001;
		end
	end

	// run pin release waits for init and input voltage
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			run_release_out <= 1'b0;
		else
			run_release_out <= init_done_in && vin_s_r[1];
	end

	// ****************************************
	// sequencing state machine
	// ****************************************
	seq_state_e st_r;
	logic [11:0] lat_r;
	logic [15:0] cnt_r;
	logic skip;
	assign skip = 32'(tonr_r) * `TICK_US < `SKIP_US;
	// fault switches off at once; a slow run path ramps down
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= ST_OFF;
			lat_r <= 12'h000;
			cnt_r <= 16'h0000;
		end
		else if (flt && st_r != ST_OFF)
			st_r <= ST_OFF;
		else
		begin
			case (st_r)
				ST_OFF:
					if (run_cond && !flt)
					begin
						st_r <= ST_ON_LAT;
						lat_r <= DLY_LD;
					end
				ST_ON_LAT:
					if (!run_cond)
						st_r <= ST_OFF;
					else if (lat_r == 12'h000)
					begin
						st_r <= ST_ON_DLY;
						cnt_r <= 16'h0000;
					end
					else
						lat_r <= lat_r - 12'h001;
				ST_ON_DLY:
					if (tick)
					begin
						if (cnt_r >= tond_r)
						begin
							st_r <= ST_RISE;
							cnt_r <= 16'h0000;
						end
						else
							cnt_r <= cnt_r + 16'h0001;
					end
				ST_RISE:
					if (skip)
						st_r <= ST_ON;
					else if (tick)
					begin
						cnt_r <= cnt_r + 16'h0001;
						if (cnt_r + 16'h0001 >= tonr_r)
							st_r <= ST_ON;
					end
				ST_ON:
					if (!run_cond)
					begin
						st_r <= ST_OFF_LAT;
						lat_r <= DLY_LD;
					end
				ST_OFF_LAT:
					if (lat_r == 12'h000)
					begin
						st_r <= ST_OFF_DLY;
						cnt_r <= 16'h0000;
					end
					else
						lat_r <= lat_r - 12'h001;
				ST_OFF_DLY:
					if (tick)
					begin
						if (cnt_r >= tofd_r)
						begin
							st_r <= ST_FALL;
							cnt_r <= 16'h0000;
						end
						else
							cnt_r <= cnt_r + 16'h0001;
					end
				ST_FALL:
					if (tick)
					begin
						cnt_r <= cnt_r + 16'h0001;
						if (cnt_r + 16'h0001 >= toff_r)
							st_r <= ST_OFF;
					end
				default: st_r <= ST_OFF;
			endcase
		end
	end

	// ****************************************
	// ramp target, droop and servo
	// ****************************************
	logic [15:0] tgt, pct_eff, i_c, drop;
	logic [47:0] drop_w;
	// floored steps of the set point over tonr_r per tick land exactly on the set point
	always_comb
	begin
		case (st_r)
			ST_RISE: tgt = 16'((32'(sp_act_r) * 32'(cnt_r))
				/ 32'(tonr_r));
			ST_FALL: tgt = sp_act_r - 16'((32'(sp_act_r)
				* 32'(cnt_r)) / 32'(toff_r));
			ST_ON, ST_OFF_LAT, ST_OFF_DLY: tgt = sp_act_r;
			default: tgt = 16'h0000;
		endcase
	end

	// slave strap kills droop; cap at 15.0 percent in 0.1 steps
	assign pct_eff = strap_s_r[1] ? 16'h0000 :
		(drp_r > `DROOP_MAX ? `DROOP_MAX : drp_r);
	// current above the warn limit does not deepen the droop
	assign i_c = iout_in > warn_r ? warn_r : iout_in;
	assign drop_w = (warn_r == 16'h0000) ? 48'h0 :
		(48'(tgt) * 48'(pct_eff) * 48'(i_c))
		/ (48'd1000 * 48'(warn_r));
	assign drop = drop_w[15:0];

	logic [15:0] tmax_cnt_r;
	logic [31:0] srv_cnt_r;
	logic signed [15:0] trim_r;
	logic servo_ok, tmax_done;
	assign tmax_done = tmax_r == 16'h0000 || tmax_cnt_r >= tmax_r;
	assign servo_ok = mode_r[`SERVO_EN_BIT] && st_r == ST_ON
		&& !flt && pct_eff == 16'h0000 && tmax_done;
	// on-max interval is counted in steps from end of rise
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			tmax_cnt_r <= 16'h0000;
		else if (st_r != ST_ON)
			tmax_cnt_r <= 16'h0000;
		else if (tick && !tmax_done)
			tmax_cnt_r <= tmax_cnt_r + 16'h0001;
	end

	// slow trim: one code per period toward the target reading
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			srv_cnt_r <= 32'h0000_0000;
			trim_r <= 16'sh0000;
		end
		else if (!servo_ok)
		begin
			srv_cnt_r <= 32'h0000_0000;
			if (st_r != ST_ON)
				trim_r <= 16'sh0000;
		end
		else if (srv_cnt_r == 32'(SERVO_CYC - 1))
		begin
			srv_cnt_r <= 32'h0000_0000;
			if (adc_vout_in < sp_act_r)
				trim_r <= trim_r + 16'sh0001;
			else if (adc_vout_in > sp_act_r)
				trim_r <= trim_r - 16'sh0001;
		end
		else
			srv_cnt_r <= srv_cnt_r + 32'h0000_0001;
	end

	// droop only subtracts from the no-load set point
	logic signed [17:0] dac_w;
	assign dac_w = 18'(signed'({2'b00, tgt})) - 18'(signed'({2'b00, drop}))
		+ 18'(trim_r);
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_out <= 16'h0000;
			range_out <= 1'b0;
		end
		else
		begin
			range_out <= ctrl_r[1];
			if (st_r == ST_OFF || dac_w < 0)
				dac_out <= 16'h0000;
			else
				dac_out <= dac_w > 18'sh0FFFF ? 16'hFFFF : dac_w[15:0];
		end
	end

	// ****************************************
	// cascade fault pin
	// ****************************************
	localparam logic [9:0] DGL_LD = 10'(`DGL_CYC - 1);
	logic uv_uf, pin_r;
	logic [9:0] dgl_r;
	assign uv_uf = prop_r[`UV_PROP_BIT] && adc_vout_in < uvt_r;
	// a level must hold 70 us before the pin follows it
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_r <= 1'b0;
			dgl_r <= 10'h000;
		end
		else if (uv_uf == pin_r)
			dgl_r <= 10'h000;
		else if (dgl_r == DGL_LD)
		begin
			pin_r <= uv_uf;
			dgl_r <= 10'h000;
		end
		else
			dgl_r <= dgl_r + 10'h001;
	end
	assign fault_pin_oe_out = pin_r;
	assign fault_pin_out = 1'b0;
	assign stat_w = {7'h00, dac_out, 3'h0, servo_ok, pin_r, st_r, 1'b0};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n);
	on_start_a: assert property ((st_r == ST_OFF && run_cond && !flt)
		|=> st_r == ST_ON_LAT) else $error("no on latency");
	lat_end_a: assert property ((st_r == ST_ON_LAT && lat_r == 12'h000
		&& run_cond && !flt) |=> st_r == ST_ON_DLY)
		else $error("latency end");
	skip_ramp_a: assert property ((st_r == ST_RISE && skip && !flt)
		|=> st_r == ST_ON) else $error("ramp not skipped");
	fault_off_a: assert property ((st_r != ST_OFF && flt)
		|=> ##1 dac_out == 16'h0000) else $error("fault not off");
	servo_gate_a: assert property ((st_r == ST_ON && $changed(trim_r))
		|-> $past(servo_ok)) else $error("servo ungated");
	droop_cap_a: assert property (48'(drop) * 48'd100 <= 48'(tgt)
		* 48'd15) else $error("droop too deep");
	slave_drp_a: assert property (strap_s_r[1] |-> drop == 16'h0000)
		else $error("slave droop");
	droop_srv_a: assert property ((drp_r != 16'h0000 && !strap_s_r[1])
		|-> !servo_ok) else $error("servo with droop");
	pin_dgl_a: assert property ($changed(pin_r) |-> $past(dgl_r) == DGL_LD)
		else $error("pin not deglitched");
	release_a: assert property (run_release_out
		|-> $past(init_done_in && vin_s_r[1])) else $error("early run");
endmodule : output_sequencing_servo_control
`default_nettype wire

// ===== verif/peer_rail_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************
// peer rail and output plant
// ************************
module peer_rail_model #(
	parameter int OFFSET = 3
)(
	input wire logic run_req_in,
	input wire logic peer_ready_in,
	input wire logic [15:0] dac_in,
	output wire logic run_out,
	output wire logic [15:0] adc_out
);
	// shared run line: no rail starts until every peer is ready
	assign run_out = run_req_in & peer_ready_in;
	// plant settles a fixed offset low, so only the trim loop can fix it
	assign adc_out = (dac_in > 16'(OFFSET)) ?
		dac_in - 16'(OFFSET) : 16'h0000;
endmodule : peer_rail_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sequencer_defines.svh"
module testbench import sequencer_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic run_req = 1'b0;
	logic vin_ok = 1'b0;
	logic init_done = 1'b0;
	logic strap = 1'b0;
	logic uv = 1'b0;
	logic oc = 1'b0;
	logic [15:0] iout = 16'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] dac;
	logic [15:0] adc;
	logic run;
	logic run_release;
	logic pin_oe;
	logic range_lvl;
	logic pin_lvl;
	logic [32:0] notes[$];
	logic [31:0] rng = 32'h5B;
	logic [31:0] aux = 32'h0;
	logic [1:0] sel = 2'h0;
	int bad_count = 0;
	int comparisons = 0;
	int chg;
	int odd;
	int first;
	event obs_ev;

	// ********************
	// design and far side
	// ********************
	output_sequencing_servo_control #(.SERVO_CYC(50)) dut (
		.clk_sys_in(clk), .arst_n_in(rst_n), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .run_in(run), .vin_ok_in(vin_ok),
		.init_done_in(init_done), .feedback_pin_strap_in(strap),
		.adc_vout_in(adc), .iout_in(iout), .undervoltage_fault_in(uv),
		.overcurrent_fault_in(oc), .dac_out(dac), .range_out(range_lvl),
		.run_release_out(run_release), .fault_pin_out(pin_lvl),
		.fault_pin_oe_out(pin_oe));
	peer_rail_model peer (.run_req_in(run_req), .peer_ready_in(1'b1),
		.dac_in(dac), .run_out(run), .adc_out(adc));

	// free-running system clock
	initial
	begin
		forever
			#50 clk = ~clk;
	end

	// ********************
	// checking helpers
	// ********************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	function automatic logic [32:0] cur(input logic [1:0] s);
		case (s)
			2'h0: return {17'h0, dac};
			2'h1: return {32'h0, pin_oe};
			2'h2: return {32'h0, run_release};
			default: return {1'b0, aux};
		endcase
	endfunction : cur

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic timeout();
		bad_count = bad_count + 1;
		$display("FAIL %0t wait ran out", $time);
		print_verdict();
	endtask : timeout

	// one idle edge first, so psel never changes twice in one step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n = n + 1;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			timeout();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		notes.push_back(exp);
		apb(1'b0, a, 16'h0000);
	endtask : rd

	// hand a note to the watcher and let it look before moving on
	task automatic probe(input logic [1:0] s, input logic [32:0] exp);
		// look off the edge, once the outputs launched by it have settled
		@(negedge clk);
		notes.push_back(exp);
		sel = s;
		-> obs_ev;
		@(posedge clk);
	endtask : probe

	task automatic settle(input logic [1:0] s, input logic [32:0] e,
		input int b);
		int n;
		n = 0;
		while (cur(s) !== e && n < b)
		begin
			@(posedge clk);
			n = n + 1;
		end
		if (cur(s) !== e)
			timeout();
		probe(s, e);
	endtask : settle

	// counts set point moves and any move that is not one whole step
	task automatic ramp(input logic [15:0] fin, input logic [15:0] step);
		int n;
		logic [15:0] last;
		n = 0;
		chg = 0;
		odd = 0;
		first = 0;
		last = dac;
		while (dac !== fin && n < 16000)
		begin
			@(posedge clk);
			n = n + 1;
			if (dac !== last)
			begin
				chg = chg + 1;
				if (chg == 1)
					first = n;
				if (dac - last != step && last - dac != step)
					odd = odd + 1;
				last = dac;
			end
		end
		if (dac !== fin)
			timeout();
	endtask : ramp

	// read data watcher: takes the oldest note at each completed read
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check({pslverr, prdata}, notes.pop_front());
	end

	// output watcher for the level checks
	always @(obs_ev)
	begin
		check(cur(sel), notes.pop_front());
	end

	// ********************
	// main sequence
	// ********************
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 15; a++)
			rd(8'(a * 4), {a == 14, 32'h0});
		for (int a = 3; a < 8; a++)
		begin
			rng = xorshift(rng);
			apb(1'b1, 8'(a * 4), rng[15:0]);
			rd(8'(a * 4), {17'h0, rng[15:0]});
		end
		apb(1'b1, `A_STAT, 16'hFFFF);
		rd(`A_STAT, 33'h0);
		apb(1'b1, `A_TOND, 16'h0000);
		apb(1'b1, `A_TONR, 16'h000A);
		apb(1'b1, `A_TOFD, 16'h0000);
		apb(1'b1, `A_TOFF, 16'h0005);
		apb(1'b1, `A_TMAX, 16'h0000);
		apb(1'b1, `A_VCMD, 16'h03E8);
		apb(1'b1, `A_CTRL, 16'h0001);
		init_done <= 1'b1;
		repeat (6) @(posedge clk);
		probe(2'h2, 33'h0);
		vin_ok <= 1'b1;
		settle(2'h2, 33'h1, 8);
		run_req <= 1'b1;
		ramp(16'h03E8, 16'h0064);
		// first step lands one tick after the delay; slack covers the syncs
		aux = {first >= (`LAT_US - `JIT_US + `TICK_US) * `CLK_MHZ
			&& first <= (`LAT_US + `JIT_US + `TICK_US) * `CLK_MHZ + 10,
			15'h0, 8'(chg), 8'(odd)};
		probe(2'h3, 33'h080000A00);
		// a new set point must sit out the processing latency
		apb(1'b1, `A_VCMD, 16'h04B0);
		repeat (2600) @(posedge clk);
		probe(2'h0, 33'h3E8);
		settle(2'h0, 33'h4B0, 1500);
		apb(1'b1, `A_WARN, 16'h0064);
		iout <= 16'h0064;
		apb(1'b1, `A_DRP, 16'h0064);
		settle(2'h0, 33'h438, 4000);
		iout <= 16'h0032;
		settle(2'h0, 33'h474, 4000);
		iout <= 16'h012C;
		settle(2'h0, 33'h438, 4000);
		apb(1'b1, `A_DRP, 16'h012C);
		settle(2'h0, 33'h3FC, 4000);
		strap <= 1'b1;
		settle(2'h0, 33'h4B0, 4000);
		strap <= 1'b0;
		settle(2'h0, 33'h3FC, 4000);
		apb(1'b1, `A_MODE, 16'h0040);
		repeat (300) @(posedge clk);
		probe(2'h0, 33'h3FC);
		apb(1'b1, `A_DRP, 16'h0000);
		settle(2'h0, 33'h4B0, 4000);
		settle(2'h0, 33'h4B3, 600);
		// cascade setup, then a fault drops the rail below threshold
		apb(1'b1, `A_MODE, 16'h0000);
		apb(1'b1, `A_UVT, 16'h01F4);
		apb(1'b1, `A_RESP, 16'h0000);
		apb(1'b1, `A_PROP, 16'h1000);
		repeat (800) @(posedge clk);
		probe(2'h1, 33'h0);
		oc <= 1'b1;
		uv <= 1'b1;
		repeat (3) @(posedge clk);
		probe(2'h0, 33'h0);
		repeat (590) @(posedge clk);
		probe(2'h1, 33'h0);
		settle(2'h1, 33'h1, 200);
		run_req <= 1'b0;
		oc <= 1'b0;
		uv <= 1'b0;
		apb(1'b1, `A_TONR, 16'h0002);
		repeat (5) @(posedge clk);
		run_req <= 1'b1;
		ramp(16'h04B0, 16'h04B0);
		aux = {16'(chg), 16'(odd)};
		probe(2'h3, 33'h000010000);
		settle(2'h1, 33'h0, 800);
		run_req <= 1'b0;
		ramp(16'h0000, 16'h00F0);
		aux = {16'(chg), 16'(odd)};
		probe(2'h3, 33'h000050000);
		// range bit follows control; open-drain pin only ever drives low
		apb(1'b1, `A_CTRL, 16'h0003);
		repeat (2) @(posedge clk);
		aux = {30'h0, range_lvl, pin_lvl};
		probe(2'h3, 33'h000000002);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
